/* logic/intc_pkg.sv */
package intc_pkg;

  // ***************************************************************
  // Register file layout
  // ***************************************************************
  localparam int NUM_REGS = 19;           // Documented registers
  localparam int NUM_SRC  = 19;           // Interrupt sources
  localparam int AW       = 12;           // Byte address width
  localparam int IDXW     = 10;           // Register index width

  // Register index; byte address is four times the index
  localparam logic [IDXW-1:0] REG_IDX [NUM_REGS] = '{
    10'h080, 10'h082, 10'h084, 10'h086, 10'h088, 10'h08C, 10'h08E,
    10'h090, 10'h094, 10'h096, 10'h098, 10'h09A, 10'h09C, 10'h09E,
    10'h0A0, 10'h0A2, 10'h0A4, 10'h0A6, 10'h0A8};
  // Implemented bits; all others read as zero
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'h871E, 16'hC007, 16'hFFFF, 16'h0081, 16'h0400, 16'hFFFF,
    16'h0081, 16'h0400, 16'h7777, 16'h7777, 16'h7777, 16'h7777,
    16'h0007, 16'h7000, 16'h0077, 16'h0000, 16'h0000, 16'h0000,
    16'h0700};
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h4444, 16'h4444, 16'h4444, 16'h4444,
    16'h0004, 16'h4000, 16'h0044, 16'h0000, 16'h0000, 16'h0000,
    16'h0400};

  // Positions in the register array
  localparam int R_CTL2  = 1;             // Second control register
  localparam int R_FLAG0 = 2;             // First flag register
  localparam int R_EN0   = 5;             // First enable register
  localparam int N_FLAG  = 3;             // Flag/enable register count

  // Control-two fields
  localparam int ALT_VEC_BIT = 15;        // Alternate table select
  localparam int EXT_POL_LSB = 0;         // Three edge polarity bits

  // Per source: flag register offset, bit, priority reg, nibble
  localparam int SRC_FREG [NUM_SRC] = '{0,0,0,0,0,0,0,0,0,0,0,0,0,0,
    0,0,1,1,2};
  localparam int SRC_FBIT [NUM_SRC] = '{0,1,2,3,4,5,6,7,8,9,10,11,12,
    13,14,15,0,7,10};
  localparam int SRC_PREG [NUM_SRC] = '{8,8,8,8,9,9,9,9,10,10,10,10,
    11,11,11,11,12,13,18};
  localparam int SRC_PNIB [NUM_SRC] = '{0,1,2,3,0,1,2,3,0,1,2,3,0,1,2,
    3,0,3,2};

  // External inputs: flag register offset and bit of each
  localparam int EXT_FREG [3] = '{0, 1, 1};
  localparam int EXT_FBIT [3] = '{0, 0, 7};

  // Event block registers (index, byte address is four times)
  localparam logic [IDXW-1:0] EVT_STAT_IDX  = 10'h0AA;
  localparam logic [IDXW-1:0] EVT_CLR_IDX   = 10'h0AC;
  localparam logic [IDXW-1:0] EVT_EN_IDX    = 10'h0AE;
  localparam int              NUM_EVT       = 4;
  localparam int              EVT_WAKE_BIT  = 3;

  // Vector addressing
  localparam logic [23:0] IVT_BASE   = 24'h000004;
  localparam logic [23:0] ALTERNATE_VECTOR_TABLE_BASE  = 24'h000084;
  localparam logic [23:0] VEC_FIRST  = 24'h000008;
  localparam int          VEC_SHIFT  = 1;  // Two address units a slot

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* logic/vector_select_ext_irq_wake.sv */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
// Function
// - Alternate select bit switches every vector table
// - Both tables share one index layout
// - Alternate table region carries no write lock
// - Shadow copies of five flags, W0-W3
// - Shadows one deep; new save overwrites
// - Shadows move only on push; pop leaves them
// - Three external inputs, own flag/enable/priority
// - External inputs react to edges only
// - Per-input polarity bit picks edge direction
// - Interrupt in sleep or idle wakes core
// - Wake and request presented together
// - Unimplemented register bits read zero
// - Pending flag interrupts only when enabled
// - Interrupt only above current core priority
module vector_select_ext_irq_wake (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External request pins
  input  wire logic [2:0]  external_irq_inputs,
  // Peripheral event pulses, one per flag bit
  input  wire logic [15:0] flag_set0,
  input  wire logic [15:0] flag_set1,
  input  wire logic [15:0] flag_set2,
  // Core state
  input  wire logic [3:0]  cpu_priority_level,
  input  wire logic        core_sleep,
  input  wire logic        core_idle,
  // Shadow save and restore
  input  wire logic        shadow_push,
  input  wire logic        shadow_pop,
  input  wire logic [4:0]  live_status,
  input  wire logic [15:0] live_w0,
  input  wire logic [15:0] live_w1,
  input  wire logic [15:0] live_w2,
  input  wire logic [15:0] live_w3,
  output logic [4:0]       shadow_status_q,
  output logic [15:0]      shadow_w0_q,
  output logic [15:0]      shadow_w1_q,
  output logic [15:0]      shadow_w2_q,
  output logic [15:0]      shadow_w3_q,
  output logic             restore_strobe_q,
  // Request to the core
  output logic             irq_req_q,
  output logic [2:0]       irq_level_q,
  output logic [4:0]       irq_index_q,
  output logic [23:0]      irq_vector_q,
  output logic             wake_q,
  // Event interrupt
  output logic             evt_irq_q
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  localparam int NUM_EVT_W = intc_pkg::NUM_EVT; // Event bits
  logic [15:0] reg_q [intc_pkg::NUM_REGS];  // Register storage
  logic [15:0] reg_d [intc_pkg::NUM_REGS];  // Next register values
  logic [15:0] hw_set [intc_pkg::NUM_REGS]; // Hardware flag sets
  logic        aw_full_q; // Write address held
  logic        w_full_q; // Write data held
  logic [11:0] aw_addr_q; // Held write address
  logic [31:0] w_data_q; // Held write data
  logic [3:0]  w_strb_q; // Held byte strobes
  logic        wr_do; // Write commits now
  logic [9:0]  wr_word; // Write register index
  logic [9:0]  rd_word; // Read register index
  logic        wr_known; // Write hits a register
  logic [31:0] rd_data; // Read mux output
  logic        rd_known; // Read hits a register
  logic [2:0]  ext_s1_q; // Pin sync first stage
  logic [2:0]  ext_s2_q; // Pin sync second stage
  logic [2:0]  ext_s3_q; // Edge history
  logic [2:0]  ext_edge; // Selected edge seen
  logic [2:0]  ext_pol; // Polarity bits
  logic        best_valid; // Some request pending
  logic [2:0]  best_prio; // Winning priority
  logic [4:0]  best_idx; // Winning source
  logic        irq_take; // Core must be interrupted
  logic [23:0] vec_base; // Selected table base
  logic [NUM_EVT_W-1:0] evt_stat_q; // Sticky events
  logic [NUM_EVT_W-1:0] evt_en_q; // Event enables
  logic [NUM_EVT_W-1:0] evt_set; // Event sources
  logic [NUM_EVT_W-1:0] evt_clr; // Software clears
  logic [NUM_EVT_W-1:0] evt_stat_d; // Next sticky state

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ***************************************************************
  // Bus slave
  // ***************************************************************
  assign wr_do   = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_word = aw_addr_q[11:2];
  assign rd_word = s_axi_araddr[11:2];

  // Address channel: hold one address until its write commits
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      aw_full_q     <= 1'b0;
      aw_addr_q     <= 12'h000;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_do)
      aw_full_q     <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  // Data channel: taken independently of the address
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      w_full_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_do)
      w_full_q     <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // Write decode: unmapped indices answer with a slave error
  always_comb
  begin
    wr_known = (wr_word == intc_pkg::EVT_CLR_IDX) ||
               (wr_word == intc_pkg::EVT_EN_IDX) ||
               (wr_word == intc_pkg::EVT_STAT_IDX);
    for (int r = 0; r < intc_pkg::NUM_REGS; r++)
      if (wr_word == intc_pkg::REG_IDX[r])
        wr_known = 1'b1;
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= intc_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? intc_pkg::RESP_OKAY
                               : intc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read mux; masks hide unimplemented bits
  always_comb
  begin
    rd_data  = 32'h00000000;
    rd_known = 1'b0;
    for (int r = 0; r < intc_pkg::NUM_REGS; r++)
      if (rd_word == intc_pkg::REG_IDX[r])
      begin
        rd_data  = {16'h0000, reg_q[r] & intc_pkg::REG_MASK[r]};
        rd_known = 1'b1;
      end
    if (rd_word == intc_pkg::EVT_STAT_IDX)
    begin
      rd_data  = {28'h0000000, evt_stat_q};
      rd_known = 1'b1;
    end
    if (rd_word == intc_pkg::EVT_EN_IDX)
    begin
      rd_data  = {28'h0000000, evt_en_q};
      rd_known = 1'b1;
    end
    if (rd_word == intc_pkg::EVT_CLR_IDX)
      rd_known = 1'b1;  // Write-only, reads zero
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= intc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_known ? intc_pkg::RESP_OKAY
                                : intc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read answer late or upper bits set");

  // ***************************************************************
  // External request inputs
  // ***************************************************************
  assign ext_pol = reg_q[intc_pkg::R_CTL2][intc_pkg::EXT_POL_LSB +: 3];

  // Two-flop synchroniser plus one history stage
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ext_s1_q <= 3'h0;
      ext_s2_q <= 3'h0;
      ext_s3_q <= 3'h0;
    end
    else
    begin
      ext_s1_q <= external_irq_inputs;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Edge select: zero picks rising, one picks falling
  assign ext_edge = (ext_s2_q & ~ext_s3_q & ~ext_pol) |
                    (~ext_s2_q & ext_s3_q & ext_pol);

  // Hardware sets: peripherals plus the three pins
  always_comb
  begin
    for (int r = 0; r < intc_pkg::NUM_REGS; r++)
      hw_set[r] = 16'h0000;
    hw_set[intc_pkg::R_FLAG0]     = flag_set0;
    hw_set[intc_pkg::R_FLAG0 + 1] = flag_set1;
    hw_set[intc_pkg::R_FLAG0 + 2] = flag_set2;
    for (int e = 0; e < 3; e++)
      if (ext_edge[e])
        hw_set[intc_pkg::R_FLAG0 + intc_pkg::EXT_FREG[e]]
              [intc_pkg::EXT_FBIT[e]] = 1'b1;
  end

  sequence ext0_rise_s;
    !ext_s3_q[0] && ext_s2_q[0] && !ext_pol[0];
  endsequence

  chk_rise_flag:
    assert property (ext0_rise_s |=> reg_q[intc_pkg::R_FLAG0][0])
    else $error("rising edge did not set flag");

  chk_level_quiet:
    assert property (ext_s2_q == ext_s3_q |-> ext_edge == 3'h0)
    else $error("steady level raised a request");

  chk_fall_polarity:
    assert property (ext_s3_q[1] && !ext_s2_q[1] && !ext_pol[1]
      |-> !ext_edge[1])
    else $error("falling edge taken under rising polarity");

  // ***************************************************************
  // Register file
  // ***************************************************************
  // Per register: byte-lane merge, then hardware set wins
  for (genvar r = 0; r < intc_pkg::NUM_REGS; r++)
  begin : g_reg
    logic        hit;                       // This register written
    logic [15:0] merged;                    // Lane-merged write value
    assign hit    = wr_do && (wr_word == intc_pkg::REG_IDX[r]);
    assign merged = {w_strb_q[1] ? w_data_q[15:8] : reg_q[r][15:8],
                     w_strb_q[0] ? w_data_q[7:0]  : reg_q[r][7:0]};
    assign reg_d[r] = ((hit ? merged : reg_q[r]) | hw_set[r]) &
                      intc_pkg::REG_MASK[r];
  end

  // All registers update together
  always_ff @(posedge mclk)
  begin
    for (int r = 0; r < intc_pkg::NUM_REGS; r++)
      if (sys_rst)
        reg_q[r] <= intc_pkg::REG_RESET[r];
      else
        reg_q[r] <= reg_d[r];
  end

  // ***************************************************************
  // Request evaluation
  // ***************************************************************
  // Highest priority wins; ties keep natural order
  always_comb
  begin
    logic       pend;
    logic [2:0] prio;
    pend       = 1'b0;
    prio       = 3'h0;
    best_valid = 1'b0;
    best_prio  = 3'h0;
    best_idx   = 5'h00;
    for (int s = 0; s < intc_pkg::NUM_SRC; s++)
    begin
      pend = reg_q[intc_pkg::R_FLAG0 + intc_pkg::SRC_FREG[s]]
                  [intc_pkg::SRC_FBIT[s]] &
             reg_q[intc_pkg::R_EN0 + intc_pkg::SRC_FREG[s]]
                  [intc_pkg::SRC_FBIT[s]];
      prio = 3'(reg_q[intc_pkg::SRC_PREG[s]] >>
                (4 * intc_pkg::SRC_PNIB[s]));
      if (pend && (!best_valid || prio > best_prio))
      begin
        best_valid = 1'b1;
        best_prio  = prio;
        best_idx   = 5'(s);
      end
    end
  end

  assign irq_take = best_valid &&
                    ({1'b0, best_prio} > cpu_priority_level);

  // Same index in either table; alternate table never locked
  assign vec_base = reg_q[intc_pkg::R_CTL2][intc_pkg::ALT_VEC_BIT] ?
                    intc_pkg::ALTERNATE_VECTOR_TABLE_BASE : intc_pkg::IVT_BASE;

  // Request, vector and wake presented in the same cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      irq_req_q    <= 1'b0;
      irq_level_q  <= 3'h0;
      irq_index_q  <= 5'h00;
      irq_vector_q <= intc_pkg::IVT_BASE;
      wake_q       <= 1'b0;
    end
    else
    begin
      irq_req_q    <= irq_take;
      irq_level_q  <= best_prio;
      irq_index_q  <= best_idx;
      irq_vector_q <= vec_base + ((intc_pkg::VEC_FIRST +
                      {19'h00000, best_idx}) << intc_pkg::VEC_SHIFT);
      wake_q       <= irq_take && (core_sleep || core_idle);
    end
  end

  chk_alt_vector:
    assert property (irq_req_q &&
      reg_q[intc_pkg::R_CTL2][intc_pkg::ALT_VEC_BIT] && $stable(reg_q[1])
      |-> irq_vector_q >= intc_pkg::ALTERNATE_VECTOR_TABLE_BASE)
    else $error("alternate table not used");

  chk_wake_with_req:
    assert property (wake_q |-> irq_req_q)
    else $error("wake without request");

  chk_sleep_wake:
    assert property (irq_take && core_sleep |=> wake_q && irq_req_q)
    else $error("sleep interrupt did not wake");

  chk_priority_gate:
    assert property (irq_req_q |-> {1'b0, irq_level_q} >
      $past(cpu_priority_level))
    else $error("request at or below core level");

  chk_enable_gate:
    assert property (reg_q[intc_pkg::R_EN0] == 16'h0000 &&
      reg_q[intc_pkg::R_EN0 + 1] == 16'h0000 &&
      reg_q[intc_pkg::R_EN0 + 2] == 16'h0000 |=> !irq_req_q)
    else $error("request with all enables clear");

  // ***************************************************************
  // Shadow context
  // ***************************************************************
  // One level only: each push overwrites; pop just strobes restore
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      {shadow_status_q, shadow_w0_q, shadow_w1_q} <= 37'h0;
      {shadow_w2_q, shadow_w3_q} <= 32'h00000000;
      restore_strobe_q <= 1'b0;
    end
    else
    begin
      restore_strobe_q <= shadow_pop;
      if (shadow_push)
      begin
        {shadow_status_q, shadow_w0_q, shadow_w1_q} <=
          {live_status, live_w0, live_w1};
        {shadow_w2_q, shadow_w3_q} <= {live_w2, live_w3};
      end
    end
  end

  sequence push_s;
    shadow_push ##1 !shadow_push [*2];
  endsequence

  chk_shadow_save:
    assert property (shadow_push |=> shadow_w0_q == $past(live_w0) &&
      shadow_status_q == $past(live_status))
    else $error("push did not capture live values");

  chk_shadow_hold:
    assert property (push_s |-> $stable(shadow_w3_q))
    else $error("shadow changed without push");

  chk_shadow_overwrite:
    assert property (shadow_push ##1 shadow_push |=>
      shadow_w1_q == $past(live_w1))
    else $error("second push did not overwrite");

  // ***************************************************************
  // Event status, clear and enable
  // ***************************************************************
  assign evt_set = {irq_take && (core_sleep || core_idle), ext_edge};
  assign evt_clr = (wr_do && wr_word == intc_pkg::EVT_CLR_IDX &&
                    w_strb_q[0]) ? w_data_q[NUM_EVT_W-1:0]
                                 : {NUM_EVT_W{1'b0}};
  // A set landing with its clear is kept
  assign evt_stat_d = (evt_stat_q & ~evt_clr) | evt_set;

  // Sticky status, enable and the level output
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      evt_stat_q <= {NUM_EVT_W{1'b0}};
      evt_en_q   <= {NUM_EVT_W{1'b0}};
      evt_irq_q  <= 1'b0;
    end
    else
    begin
      evt_stat_q <= evt_stat_d;
      if (wr_do && wr_word == intc_pkg::EVT_EN_IDX && w_strb_q[0])
        evt_en_q <= w_data_q[NUM_EVT_W-1:0];
      evt_irq_q  <= |(evt_stat_d & evt_en_q);
    end
  end

endmodule

/* tb/core_model.sv */
`timescale 1ns/100ps
// Core and peripheral side: pins, event pulses, core state, shadows
module core_model (
  // Clock
  input  wire logic        mclk,
  // Pins and peripheral pulses
  output logic [2:0]       external_irq_inputs,
  output logic [15:0]      flag_set0,
  output logic [15:0]      flag_set1,
  output logic [15:0]      flag_set2,
  // Core state
  output logic [3:0]       cpu_priority_level,
  output logic             core_sleep,
  output logic             core_idle,
  // Shadow traffic
  output logic             shadow_push,
  output logic             shadow_pop,
  output logic [4:0]       live_status,
  output logic [15:0]      live_w0,
  output logic [15:0]      live_w1,
  output logic [15:0]      live_w2,
  output logic [15:0]      live_w3
);
  // Quiet core, pins low
  initial
  begin
    {external_irq_inputs, flag_set0, flag_set1, flag_set2} = '0;
    {cpu_priority_level, core_sleep, core_idle} = '0;
    {shadow_push, shadow_pop, live_status} = '0;
    {live_w0, live_w1, live_w2, live_w3} = '0;
  end
  // Pin levels
  task automatic pins(input logic [2:0] p);
    external_irq_inputs <= p;
  endtask
  // One-cycle peripheral event pulses
  task automatic fset(input logic [15:0] a, b, c);
    {flag_set0, flag_set1, flag_set2} <= {a, b, c};
    @(posedge mclk);
    {flag_set0, flag_set1, flag_set2} <= '0;
  endtask
  // Core priority and power state
  task automatic state(input logic [3:0] l, input logic s, i);
    {cpu_priority_level, core_sleep, core_idle} <= {l, s, i};
  endtask
  // Fast save, used by one routine level only, never nested
  task automatic save(input logic [4:0] s, input logic [15:0] w);
    {live_status, live_w0, live_w1} <= {s, w, ~w};
    {live_w2, live_w3} <= {w ^ 16'h00FF, w ^ 16'hFF00};
    shadow_push <= 1'h1;
    @(posedge mclk);
    shadow_push <= 1'h0;
    // Live values move on; shadows stay
    {live_status, live_w0} <= {~s, ~w};
  endtask
  // Fast restore
  task automatic restore;
    shadow_pop <= 1'h1;
    @(posedge mclk);
    shadow_pop <= 1'h0;
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %s exp %h seen %h", n, e, g); end end
module testbench;
  // ***************************************************************
  // Signals, named as the ports
  // ***************************************************************
  logic        mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, core_sleep;
  logic        core_idle, shadow_push, shadow_pop, restore_strobe_q;
  logic        irq_req_q, wake_q, evt_irq_q;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, cpu_priority_level;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  external_irq_inputs, irq_level_q;
  logic [15:0] flag_set0, flag_set1, flag_set2, live_w0, live_w1;
  logic [15:0] live_w2, live_w3, shadow_w0_q, shadow_w1_q;
  logic [15:0] shadow_w2_q, shadow_w3_q;
  logic [4:0]  live_status, shadow_status_q, irq_index_q;
  logic [23:0] irq_vector_q;
  int          fail_count, check_count;   // Mismatches, comparisons
  logic [3:0]  lanes = 4'hF;              // Write byte strobes

  vector_select_ext_irq_wake u_vector_select_ext_irq_wake (.*);
  core_model                 u_core_model (.*);

  // Free-running 10 MHz clock
  always #50 mclk = ~mclk;

  // ***************************************************************
  // Closing report and bus tasks
  // ***************************************************************
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A wait ran out: count it and stop
  task automatic lost;
    fail_count++;
    complete_run();
  endtask
  // Let n edges pass
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Write one register
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] r);
    int n;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, d, lanes};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40 && !s_axi_bvalid; n++)
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    if (n == 40)
      lost();
    `CK("bresp", r, s_axi_bresp)
    s_axi_bready <= 1'h0;
    @(posedge mclk);
  endtask
  // Read one register; upper half zero
  task automatic rd(input logic [11:0] a, input logic [15:0] e,
                    input logic [1:0] r);
    int n;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (n = 0; n < 40 && !s_axi_rvalid; n++)
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    if (n == 40)
      lost();
    `CK("rdata", {16'h0000, e}, s_axi_rdata)
    `CK("rresp", r, s_axi_rresp)
    s_axi_rready <= 1'h0;
    @(posedge mclk);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  // Reset values, reserved bits, unmapped place, event pulses
  task automatic t_regs;
    rd(12'h208, 16'h0000, 2'h0);
    rd(12'h270, 16'h0004, 2'h0);
    rd(12'h278, 16'h4000, 2'h0);
    rd(12'h280, 16'h0044, 2'h0);
    rd(12'h288, 16'h0000, 2'h0);
    rd(12'h2A0, 16'h0400, 2'h0);
    wr(12'h250, 16'hFFFF, 2'h0);
    rd(12'h250, 16'h7777, 2'h0);
    lanes = 4'h1;
    wr(12'h250, 16'h0000, 2'h0);
    lanes = 4'hF;
    rd(12'h250, 16'h7700, 2'h0);
    wr(12'h208, 16'hFFFF, 2'h0);
    rd(12'h208, 16'hC007, 2'h0);
    wr(12'h208, 16'h0000, 2'h0);
    wr(12'h250, 16'h4444, 2'h0);
    wr(12'h3FC, 16'hFFFF, 2'h2);
    rd(12'h3FC, 16'h0000, 2'h2);
    u_core_model.fset(16'h8000, 16'h0080, 16'h0400);
    rd(12'h210, 16'h8000, 2'h0);
    rd(12'h218, 16'h0080, 2'h0);
    rd(12'h220, 16'h0400, 2'h0);
    wr(12'h218, 16'h0000, 2'h0);
    wr(12'h210, 16'h0000, 2'h0);
    wr(12'h220, 16'h0000, 2'h0);
    $display("Test registers done");
  endtask
  // Pin edges of both polarities, then the request
  task automatic t_pins;
    u_core_model.pins(3'h7);
    cyc(8);
    rd(12'h210, 16'h0001, 2'h0);
    rd(12'h218, 16'h0081, 2'h0);
    wr(12'h210, 16'h0000, 2'h0);
    wr(12'h218, 16'h0000, 2'h0);
    cyc(8);
    rd(12'h218, 16'h0000, 2'h0);
    u_core_model.pins(3'h0);
    cyc(8);
    rd(12'h210, 16'h0000, 2'h0);
    wr(12'h208, 16'h0007, 2'h0);
    u_core_model.pins(3'h7);
    cyc(8);
    rd(12'h218, 16'h0000, 2'h0);
    u_core_model.pins(3'h0);
    cyc(8);
    rd(12'h210, 16'h0001, 2'h0);
    rd(12'h218, 16'h0081, 2'h0);
    `CK("irq", 1'h0, irq_req_q)
    wr(12'h218, 16'h0000, 2'h0);
    wr(12'h230, 16'h0001, 2'h0);
    cyc(3);
    `CK("irq", 1'h1, irq_req_q)
    `CK("level", 3'h4, irq_level_q)
    `CK("index", 5'h00, irq_index_q)
    `CK("vec", intc_pkg::IVT_BASE + 24'h000010, irq_vector_q)
    u_core_model.state(4'h4, 1'h0, 1'h0);
    cyc(3);
    `CK("irq", 1'h0, irq_req_q)
    u_core_model.state(4'h3, 1'h0, 1'h0);
    cyc(3);
    `CK("irq", 1'h1, irq_req_q)
    $display("Test pins done");
  endtask
  // Alternate table, then waking from sleep and idle
  task automatic t_vec_wake;
    wr(12'h208, 16'h8007, 2'h0);
    cyc(3);
    `CK("vec", intc_pkg::ALTERNATE_VECTOR_TABLE_BASE + 24'h000010, irq_vector_q)
    `CK("wake", 1'h0, wake_q)
    u_core_model.state(4'h3, 1'h1, 1'h0);
    cyc(3);
    `CK("wake", 1'h1, wake_q)
    `CK("irq", 1'h1, irq_req_q)
    u_core_model.state(4'h7, 1'h1, 1'h0);
    cyc(3);
    `CK("wake", 1'h0, wake_q)
    u_core_model.state(4'h3, 1'h0, 1'h1);
    cyc(3);
    `CK("wake", 1'h1, wake_q)
    u_core_model.state(4'h3, 1'h0, 1'h0);
    $display("Test vector and wake done");
  endtask
  // Event status: set by a pin edge, masked, enabled, cleared
  task automatic t_evt;
    wr(12'h2B0, 16'h000F, 2'h0);
    rd(12'h2A8, 16'h0000, 2'h0);
    u_core_model.pins(3'h1);
    cyc(8);
    u_core_model.pins(3'h0);
    cyc(8);
    rd(12'h2A8, 16'h0001, 2'h0);
    `CK("evt", 1'h0, evt_irq_q)
    wr(12'h2B8, 16'h0001, 2'h0);
    cyc(3);
    `CK("evt", 1'h1, evt_irq_q)
    rd(12'h2B0, 16'h0000, 2'h0);
    wr(12'h2B0, 16'h0001, 2'h0);
    cyc(3);
    `CK("evt", 1'h0, evt_irq_q)
    $display("Test events done");
  endtask
  // Saves overwrite; restore leaves shadows
  task automatic t_shadow;
    logic [2:0] k;
    u_core_model.save(5'h15, 16'hA5A5);
    @(posedge mclk);
    `CK("sh_w0", 16'hA5A5, shadow_w0_q)
    u_core_model.save(5'h0A, 16'h1234);
    cyc(3);
    `CK("sh_st", 5'h0A, shadow_status_q)
    `CK("sh_w0", 16'h1234, shadow_w0_q)
    `CK("sh_w1", 16'hEDCB, shadow_w1_q)
    `CK("sh_w2", 16'h12CB, shadow_w2_q)
    `CK("sh_w3", 16'hED34, shadow_w3_q)
    u_core_model.restore();
    k = 3'h0;
    repeat (4)
    begin
      @(posedge mclk);
      k = k + {2'h0, restore_strobe_q};
    end
    `CK("strobe", 3'h1, k)
    `CK("sh_w0", 16'h1234, shadow_w0_q)
    $display("Test shadows done");
  endtask

  // Ten reset cycles, then every scenario
  initial
  begin
    {mclk, sys_rst, fail_count, check_count} = {2'h1, 64'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    t_regs();
    t_pins();
    t_vec_wake();
    t_evt();
    t_shadow();
    complete_run();
  end
endmodule
